//--- sls_map.svh
/*
  Register map and timing constants for the sensor status / I2C read link.
  Assumes inclusion by bare name from the package and both link ends.
*/
`ifndef SLS_MAP_SVH
`define SLS_MAP_SVH
`define SLS_ADDR_WR 8'h26
`define SLS_ADDR_RD 8'h27
`define SLS_REG_LOW_HI 8'h8A
`define SLS_REG_LOW_LO 8'h8B
`define SLS_REG_HIGH_HI 8'h8C
`define SLS_REG_HIGH_LO 8'h8D
`define SLS_REG_IRQ 8'h8E
`define SLS_REG_MOD 8'h8F
`define SLS_REG_AMB 8'h90
`define SLS_BIT_PROX 3
`define SLS_BIT_ALS 2
`define SLS_BIT_LOW 1
`define SLS_BIT_HIGH 0
`define SLS_MOD_RESET 8'h01
`define SLS_LOW_RESET 16'h0000
`define SLS_HIGH_RESET 16'hFFFF
`define SLS_SCL_HALF 16
`define SLS_CSR_CMD 8'h00
`define SLS_CSR_WDATA 8'h04
`define SLS_CSR_STATUS 8'h08
`define SLS_CSR_RDATA 8'h0C
`define SLS_CSR_EVT 8'h10
`define SLS_CSR_MASK 8'h14
`endif

//--- sls_pkg.sv
/*
  Shared types for the sensor status link: bus operations of the host end.
  Assumes sls_map.svh in the same folder.
*/
package sls_pkg;
  `include "sls_map.svh"
  // Host bit-level operations
  typedef enum logic [4:0] {
    SLS_OP_IDLE  = 5'b00001,
    SLS_OP_START = 5'b00010,
    SLS_OP_BYTE  = 5'b00100,
    SLS_OP_ACK   = 5'b01000,
    SLS_OP_STOP  = 5'b10000
  } sls_op_e;
endpackage

//--- sls_if.sv
/*
  Two-wire link between host controller and sensor device.
  Assumes the bench resolves the open-drain wire from the enables.
*/
`timescale 1ns/100ps
interface sls_if;
  logic scl_o_host; // Host clock drive, low when enable low
  logic scl_oen_host; // Low while host pulls clock
  logic sda_o_host; // Host data drive value
  logic sda_oen_host; // Low while host pulls data
  logic sda_o_dev; // Device data drive value
  logic sda_oen_dev; // Low while device pulls data
  logic scl; // Resolved clock level
  logic sda; // Resolved data level
  logic int_n; // Device interrupt pad, active low
  assign scl = scl_oen_host ? 1'b1 : scl_o_host;
  assign sda = (sda_oen_host | sda_o_host) & (sda_oen_dev | sda_o_dev);
  modport host (output scl_o_host, scl_oen_host, sda_o_host, sda_oen_host,
    input scl, sda, int_n);
  modport dev (output sda_o_dev, sda_oen_dev, int_n, input scl, sda);
endinterface // sls_if

//--- sls_dev.sv
/*
  Device end: I2C slave with register pointer, limits, sticky interrupt
  flags, modulator timing register and standby emitter gating.
  Assumes the link clock is far slower than clock_i (oversampled).
*/
// Design decision made here: the I2C slave interface to the registers.
`timescale 1ns/100ps
`include "sls_map.svh"
module sls_dev
  import sls_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  sls_if.dev link,
  input wire logic prox_done_i, // Proximity measurement complete pulse
  input wire logic als_done_i, // Light measurement complete pulse
  input wire logic [15:0] meas_i, // Measurement value for limits
  input wire logic meas_valid_i, // Value strobe for limit compare
  input wire logic meas_req_i, // Any measurement requested
  input wire logic [7:0] ambient_i, // Internal ambient IR level
  input wire logic led_en_i, // Emitter sink wanted by sequencer
  output logic led_sink_o, // Emitter sink actually on
  output logic standby_o, // Device in standby
  output logic [7:0] mod_timing_o // Modulator timing fields
);
  // Synchronisers for both link wires
  logic [1:0] scl_s_reg;
  logic [1:0] sda_s_reg;
  logic scl_d_reg; // Previous synchronised clock
  logic sda_d_reg; // Previous synchronised data
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      scl_s_reg <= 2'b11;
      sda_s_reg <= 2'b11;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_s_reg <= {scl_s_reg[0], link.scl};
      sda_s_reg <= {sda_s_reg[0], link.sda};
      scl_d_reg <= scl_s_reg[1];
      sda_d_reg <= sda_s_reg[1];
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl_s_reg[1] & ~scl_d_reg;
  assign scl_fall = ~scl_s_reg[1] & scl_d_reg;
  // Start and stop seen while clock high; covers repeated start too
  assign start_ev = scl_s_reg[1] & scl_d_reg & sda_d_reg & ~sda_s_reg[1];
  assign stop_ev = scl_s_reg[1] & scl_d_reg & ~sda_d_reg & sda_s_reg[1];

  // Protocol state
  typedef enum logic [4:0] {
    SLS_D_IDLE = 5'b00001,
    SLS_D_ADDR = 5'b00010,
    SLS_D_WACK = 5'b00100,
    SLS_D_WDAT = 5'b01000,
    SLS_D_RDAT = 5'b10000
  } sls_dstate_e;
  sls_dstate_e st_reg;
  logic [3:0] bit_reg; // Bits of current byte taken
  logic [7:0] sh_reg; // Shift register, in or out
  logic ack_reg; // In acknowledge slot
  logic rd_mode_reg; // Transfer is a read
  logic first_reg; // Next written byte is register address
  logic mack_reg; // Host acknowledged last read byte
  logic [7:0] ptr_reg; // Internal register pointer
  logic [7:0] rdata; // Selected register contents
  logic wr_strobe; // Data byte written to pointer
  logic rd_done; // Read byte acknowledged phase done
  logic [7:0] rd_ptr; // Pointer that the read mux decodes

  // Registers of the device
  logic [3:0] flags_reg;
  logic [7:0] mod_reg;
  logic [15:0] low_reg;
  logic [15:0] high_reg;

  // Read mux; unused flag bits read zero. The reload after a read byte
  // must see the advanced pointer, or the same register repeats.
  assign rd_ptr = rd_done ? ptr_reg + 8'h01 : ptr_reg;
  always_comb begin
    case (rd_ptr)
      `SLS_REG_LOW_HI: rdata = low_reg[15:8];
      `SLS_REG_LOW_LO: rdata = low_reg[7:0];
      `SLS_REG_HIGH_HI: rdata = high_reg[15:8];
      `SLS_REG_HIGH_LO: rdata = high_reg[7:0];
      `SLS_REG_IRQ: rdata = {4'h0, flags_reg};
      `SLS_REG_MOD: rdata = mod_reg;
      `SLS_REG_AMB: rdata = ambient_i;
      default: rdata = 8'h00; // Unmapped reads zero
    endcase
  end

  // Byte engine: sample on rising clock, drive on falling clock
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      st_reg <= SLS_D_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      ack_reg <= 1'b0;
      rd_mode_reg <= 1'b0;
      first_reg <= 1'b0;
      mack_reg <= 1'b0;
    end else if (start_ev) begin
      // Repeated start same as start; pointer kept
      st_reg <= SLS_D_ADDR;
      bit_reg <= 4'h0;
      ack_reg <= 1'b0;
    end else if (stop_ev) begin
      st_reg <= SLS_D_IDLE;
      ack_reg <= 1'b0;
    end else begin
      case (st_reg)
        SLS_D_ADDR, SLS_D_WDAT: begin
          if (scl_rise && !ack_reg) begin
            sh_reg <= {sh_reg[6:0], sda_s_reg[1]};
            bit_reg <= bit_reg + 4'h1;
          end
          if (scl_fall && bit_reg == 4'h8 && !ack_reg) begin
            if (st_reg == SLS_D_ADDR) begin
              // Only our two address bytes are acknowledged
              if (sh_reg[7:1] == 7'(`SLS_ADDR_WR >> 1)) begin
                ack_reg <= 1'b1;
                rd_mode_reg <= sh_reg[0];
                first_reg <= ~sh_reg[0];
              end else begin
                st_reg <= SLS_D_IDLE;
              end
            end else begin
              ack_reg <= 1'b1;
              first_reg <= 1'b0;
            end
          end else if (scl_fall && ack_reg) begin
            ack_reg <= 1'b0;
            bit_reg <= 4'h0;
            if (rd_mode_reg) begin
              st_reg <= SLS_D_RDAT;
              sh_reg <= rdata;
            end else begin
              st_reg <= SLS_D_WDAT;
            end
          end
        end
        SLS_D_RDAT: begin
          if (scl_fall && !ack_reg && bit_reg != 4'h8) begin
            if (bit_reg == 4'h7) begin
              ack_reg <= 1'b1;
            end else begin
              sh_reg <= {sh_reg[6:0], 1'b0};
            end
            bit_reg <= bit_reg + 4'h1;
          end else if (scl_fall && bit_reg != 4'h8) begin
            bit_reg <= bit_reg + 4'h1;
          end
          if (ack_reg && scl_rise) begin
            mack_reg <= ~sda_s_reg[1];
          end
          if (ack_reg && scl_fall) begin
            // Acknowledge slot over; continue only if host acked
            ack_reg <= 1'b0;
            bit_reg <= 4'h0;
            sh_reg <= rdata;
            if (!mack_reg) begin
              st_reg <= SLS_D_IDLE;
            end
          end
        end
        default: st_reg <= SLS_D_IDLE; // Idle waits for start
      endcase
    end
  end
  assign wr_strobe = (st_reg == SLS_D_WDAT) && scl_fall && bit_reg == 4'h8
    && !ack_reg && !start_ev && !stop_ev;
  assign rd_done = (st_reg == SLS_D_RDAT) && ack_reg && scl_fall
    && !start_ev && !stop_ev;

  // Pointer: set by address byte, advanced after each data byte written or read
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ptr_reg <= 8'h00;
    end else if (wr_strobe && first_reg) begin
      ptr_reg <= sh_reg;
    end else if (wr_strobe || rd_done) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // Data drive: pull low for ack in write, or for zero read bits
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      link.sda_o_dev <= 1'b1;
      link.sda_oen_dev <= 1'b1;
    end else begin
      link.sda_o_dev <= 1'b0;
      if (st_reg == SLS_D_RDAT && !ack_reg) begin
        link.sda_oen_dev <= sh_reg[7];
      end else if (ack_reg && st_reg != SLS_D_RDAT) begin
        link.sda_oen_dev <= 1'b0;
      end else begin
        link.sda_oen_dev <= 1'b1;
      end
    end
  end

  // Writable configuration registers
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      mod_reg <= `SLS_MOD_RESET;
      low_reg <= `SLS_LOW_RESET;
      high_reg <= `SLS_HIGH_RESET;
    end else if (wr_strobe && !first_reg) begin
      case (ptr_reg)
        `SLS_REG_MOD: mod_reg <= sh_reg;
        `SLS_REG_LOW_HI: low_reg[15:8] <= sh_reg;
        `SLS_REG_LOW_LO: low_reg[7:0] <= sh_reg;
        `SLS_REG_HIGH_HI: high_reg[15:8] <= sh_reg;
        `SLS_REG_HIGH_LO: high_reg[7:0] <= sh_reg;
        default: ; // Read-only or unmapped: ignored
      endcase
    end
  end

  // Sticky flags; an event in the clearing cycle wins
  logic [3:0] ev;
  logic [3:0] clr;
  always_comb begin
    ev = 4'h0;
    ev[`SLS_BIT_PROX] = prox_done_i;
    ev[`SLS_BIT_ALS] = als_done_i;
    ev[`SLS_BIT_LOW] = meas_valid_i && meas_i < low_reg;
    ev[`SLS_BIT_HIGH] = meas_valid_i && meas_i > high_reg;
    clr = (wr_strobe && !first_reg && ptr_reg == `SLS_REG_IRQ)
      ? sh_reg[3:0] : 4'h0;
  end
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      flags_reg <= 4'h0;
    end else begin
      flags_reg <= (flags_reg & ~clr) | ev;
    end
  end

  // Pad low while any flag set
  assign link.int_n = ~|flags_reg;
  assign standby_o = ~meas_req_i;
  assign led_sink_o = led_en_i & meas_req_i;
  assign mod_timing_o = mod_reg;
endmodule // sls_dev

//--- sls_host.sv
/*
  Host end: AXI4-Lite slave with command registers, driving an I2C
  master that addresses then reads sensor registers.
  Assumes the bench resolves the wires and drives AXI per the protocol.
*/
`timescale 1ns/100ps
`include "sls_map.svh"
module sls_host
  import sls_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  sls_if.host link,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic irq_o // Level: unmasked event pending
);
  // AXI write capture
  logic aw_ok_reg;
  logic w_ok_reg;
  logic [7:0] awa_reg;
  logic [31:0] wd_reg;
  logic [3:0] cmd_reg; // [0]=go [1]=addr phase [2]=read [3]=stop
  logic [7:0] wbyte_reg; // Byte to send
  logic [7:0] rbyte_reg; // Byte received
  logic busy_reg;
  logic [1:0] evt_reg; // [0]=done [1]=nack
  logic [1:0] mask_reg;
  logic [1:0] int_s_reg; // Pad synchroniser
  logic done_ev;
  logic nack_ev;
  logic wr_do;
  assign awready_o = ~aw_ok_reg & ~bvalid_o;
  assign wready_o = ~w_ok_reg & ~bvalid_o;
  assign wr_do = aw_ok_reg & w_ok_reg & ~bvalid_o;
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      aw_ok_reg <= 1'b0;
      w_ok_reg <= 1'b0;
      awa_reg <= 8'h00;
      wd_reg <= 32'h0;
      bvalid_o <= 1'b0;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_ok_reg <= 1'b1;
        awa_reg <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        w_ok_reg <= 1'b1;
        wd_reg <= wstrb_i[0] ? wdata_i : 32'h0;
      end
      if (wr_do) begin
        aw_ok_reg <= 1'b0;
        w_ok_reg <= 1'b0;
        bvalid_o <= 1'b1;
      end else if (bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end
  assign bresp_o = 2'b00;

  // Read channel; reading events clears them, new events win
  logic rd_evt;
  assign arready_o = ~rvalid_o;
  assign rd_evt = arvalid_i & arready_o & (araddr_i == `SLS_CSR_EVT);
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0;
    end else if (arvalid_i && arready_o) begin
      rvalid_o <= 1'b1;
      case (araddr_i)
        `SLS_CSR_CMD: rdata_o <= {28'h0, cmd_reg};
        `SLS_CSR_WDATA: rdata_o <= {24'h0, wbyte_reg};
        `SLS_CSR_STATUS: rdata_o <= {29'h0, ~int_s_reg[1], 1'b0, busy_reg};
        `SLS_CSR_RDATA: rdata_o <= {24'h0, rbyte_reg};
        `SLS_CSR_EVT: rdata_o <= {30'h0, evt_reg};
        `SLS_CSR_MASK: rdata_o <= {30'h0, mask_reg};
        default: rdata_o <= 32'h0;
      endcase
    end else if (rready_i) begin
      rvalid_o <= 1'b0;
    end
  end
  assign rresp_o = 2'b00;
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      evt_reg <= 2'b00;
      int_s_reg <= 2'b11;
    end else begin
      evt_reg <= (rd_evt ? 2'b00 : evt_reg) | {nack_ev, done_ev};
      int_s_reg <= {int_s_reg[0], link.int_n};
    end
  end
  assign irq_o = |(evt_reg & mask_reg);

  // Bit engine: one byte and ack per command, start and stop as asked
  sls_op_e op_reg;
  logic [15:0] div_reg; // Quarter-period counter
  logic [1:0] ph_reg; // Quarter phase in bit
  logic [3:0] n_reg; // Bits left
  logic [7:0] sh_reg;
  logic sda_in_reg; // Sampled data, after sync
  logic [1:0] sda_s_reg;
  logic tick;
  assign tick = (div_reg == 16'(`SLS_SCL_HALF - 1));
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      sda_s_reg <= 2'b11;
    end else begin
      sda_s_reg <= {sda_s_reg[0], link.sda};
    end
  end
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      cmd_reg <= 4'h0;
      wbyte_reg <= 8'h00;
      mask_reg <= 2'b00;
    end else if (wr_do && awa_reg == `SLS_CSR_CMD && !busy_reg) begin
      cmd_reg <= wd_reg[3:0];
    end else if (wr_do && awa_reg == `SLS_CSR_WDATA) begin
      wbyte_reg <= wd_reg[7:0];
    end else if (wr_do && awa_reg == `SLS_CSR_MASK) begin
      mask_reg <= wd_reg[1:0];
    end else if (busy_reg) begin
      cmd_reg[0] <= 1'b0;
    end
  end
  // Sequencer: start (if addr) / byte / ack / stop (if asked)
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      op_reg <= SLS_OP_IDLE;
      busy_reg <= 1'b0;
      div_reg <= 16'h0;
      ph_reg <= 2'b00;
      n_reg <= 4'h0;
      sh_reg <= 8'h00;
      rbyte_reg <= 8'h00;
      sda_in_reg <= 1'b1;
      done_ev <= 1'b0;
      nack_ev <= 1'b0;
      link.scl_o_host <= 1'b0;
      link.scl_oen_host <= 1'b1;
      link.sda_o_host <= 1'b0;
      link.sda_oen_host <= 1'b1;
    end else begin
      done_ev <= 1'b0;
      nack_ev <= 1'b0;
      div_reg <= tick ? 16'h0 : div_reg + 16'h1;
      case (op_reg)
        SLS_OP_IDLE: begin
          if (cmd_reg[0] && !busy_reg) begin
            busy_reg <= 1'b1;
            ph_reg <= 2'b00;
            n_reg <= 4'h8;
            sh_reg <= wbyte_reg;
            op_reg <= cmd_reg[1] ? SLS_OP_START : SLS_OP_BYTE;
          end
        end
        SLS_OP_START: if (tick) begin
          // Release data, raise clock, then pull data low
          ph_reg <= ph_reg + 2'b01;
          case (ph_reg)
            2'b00: link.sda_oen_host <= 1'b1;
            2'b01: link.scl_oen_host <= 1'b1;
            2'b10: link.sda_oen_host <= 1'b0;
            default: begin
              link.scl_oen_host <= 1'b0;
              op_reg <= SLS_OP_BYTE;
            end
          endcase
        end
        SLS_OP_BYTE, SLS_OP_ACK: if (tick) begin
          ph_reg <= ph_reg + 2'b01;
          case (ph_reg)
            2'b00: link.sda_oen_host <= (op_reg == SLS_OP_BYTE)
              ? (cmd_reg[2] | sh_reg[7]) : (~cmd_reg[2] | cmd_reg[3]);
            2'b01: link.scl_oen_host <= 1'b1;
            2'b10: sda_in_reg <= sda_s_reg[1];
            default: begin
              link.scl_oen_host <= 1'b0;
              if (op_reg == SLS_OP_BYTE) begin
                sh_reg <= {sh_reg[6:0], sda_in_reg};
                n_reg <= n_reg - 4'h1;
                if (n_reg == 4'h1) begin
                  op_reg <= SLS_OP_ACK;
                end
              end else begin
                rbyte_reg <= sh_reg;
                nack_ev <= ~cmd_reg[2] & sda_in_reg;
                op_reg <= cmd_reg[3] ? SLS_OP_STOP : SLS_OP_IDLE;
                busy_reg <= cmd_reg[3];
                done_ev <= ~cmd_reg[3];
              end
            end
          endcase
        end
        SLS_OP_STOP: if (tick) begin
          ph_reg <= ph_reg + 2'b01;
          case (ph_reg)
            2'b00: link.sda_oen_host <= 1'b0;
            2'b01: link.scl_oen_host <= 1'b1;
            2'b10: link.sda_oen_host <= 1'b1;
            default: begin
              op_reg <= SLS_OP_IDLE;
              busy_reg <= 1'b0;
              done_ev <= 1'b1;
            end
          endcase
        end
        default: op_reg <= SLS_OP_IDLE;
      endcase
    end
  end
endmodule // sls_host

//--- sls_props.sv
/*
  Wire checker for the sensor status link.
  Assumes the bench passes the sls_if signals to it by name.
*/
`timescale 1ns/100ps
module sls_props (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic scl_o_host,
  input wire logic scl_oen_host,
  input wire logic sda_o_dev,
  input wire logic sda_oen_dev,
  input wire logic scl,
  input wire logic sda,
  input wire logic int_n
);
  logic scl_d_reg; // Clock wire one cycle back
  logic [7:0] idle_reg; // Quiet cycles on the clock wire, saturating
  // Idle count restarts on each clock wire edge
  always_ff @(posedge clock_i) begin
    scl_d_reg <= scl;
    if (!rstn_i || scl != scl_d_reg) begin
      idle_reg <= 8'h00;
    end else if (idle_reg != 8'hFF) begin
      idle_reg <= idle_reg + 8'h01;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  property p_dev_od; !sda_oen_dev |-> !sda_o_dev; endproperty
  property p_dev_hold; scl && $past(scl) |-> $stable(sda_oen_dev); endproperty
  property p_host_od; !scl_oen_host |-> !scl_o_host; endproperty
  // Clock enable holds eight cycles at least after each change
  property p_scl_phase;
    $changed(scl_oen_host) |=> $stable(scl_oen_host) [*8];
  endproperty
  property p_start; scl && $past(scl) && $fell(sda) |-> ##[1:64] !scl;
  endproperty
  property p_stop; scl && $past(scl) && $rose(sda) |-> sda_oen_dev [*8];
  endproperty
  // Flags only clear through link writes, so never on a quiet wire
  property p_sticky; idle_reg >= 8'h10 |-> !$rose(int_n); endproperty
  property p_rst; $rose(rstn_i) |-> int_n && sda_oen_dev && scl_oen_host;
  endproperty
  a_dev_od: assert property (p_dev_od)
    else $error("device drove sda high");
  a_dev_hold: assert property (p_dev_hold)
    else $error("device moved sda with scl high");
  a_host_od: assert property (p_host_od)
    else $error("host drove scl high");
  a_scl_phase: assert property (p_scl_phase)
    else $error("scl phase too short");
  a_start: assert property (p_start)
    else $error("no clock after start");
  a_stop: assert property (p_stop)
    else $error("device pulled sda after stop");
  a_sticky: assert property (p_sticky)
    else $error("interrupt released with link quiet");
  a_rst: assert property (p_rst)
    else $error("link not released after reset");
  c_int: cover property ($fell(int_n));
  c_ack: cover property ($fell(sda_oen_dev));
  c_clr: cover property ($rose(int_n));
endmodule // sls_props

//--- testbench.sv
/*
  Testbench: host and device ends joined by sls_if, driven over AXI.
  Assumes the design files and sls_props.sv are compiled first.
*/
`timescale 1ns/100ps
`include "sls_map.svh"
module testbench
  import sls_pkg::*;
;
  logic clock_i = 1'b0; // 200 MHz
  logic rstn_i = 1'b0; // Sync reset, active low
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic prox_done = 1'b0; // Device event strobes
  logic als_done = 1'b0;
  logic [15:0] meas = 16'h0;
  logic meas_valid = 1'b0;
  logic meas_req = 1'b1;
  logic [7:0] ambient = 8'h00;
  logic led_en = 1'b0;
  logic led_sink, standby;
  logic [7:0] mod_timing;
  int err_count = 0;
  int num_checks = 0;
  sls_if link_if ();
  always #2.5 clock_i = ~clock_i;
  sls_dev i_sls_dev (.clock_i(clock_i), .rstn_i(rstn_i), .link(link_if),
    .prox_done_i(prox_done), .als_done_i(als_done), .meas_i(meas),
    .meas_valid_i(meas_valid), .meas_req_i(meas_req), .ambient_i(ambient),
    .led_en_i(led_en), .led_sink_o(led_sink), .standby_o(standby),
    .mod_timing_o(mod_timing));
  sls_host i_sls_host (.clock_i(clock_i), .rstn_i(rstn_i), .link(link_if),
    .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
    .wdata_i(wdata), .wstrb_i(4'hF), .wvalid_i(wvalid), .wready_o(wready),
    .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr),
    .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
    .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready), .irq_o(irq));
  sls_props i_sls_props (.clock_i(clock_i), .rstn_i(rstn_i),
    .scl_o_host(link_if.scl_o_host), .scl_oen_host(link_if.scl_oen_host),
    .sda_o_dev(link_if.sda_o_dev), .sda_oen_dev(link_if.sda_oen_dev),
    .scl(link_if.scl), .sda(link_if.sda), .int_n(link_if.int_n));
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // A bound ran out: count it and stop
  task automatic hung(input string nm);
    chk(nm, 32'h1, 32'h0);
    test_done();
  endtask
  // Expected limit flags of one sample
  function automatic logic [7:0] lim_flags(input logic [15:0] m, lo, hi);
    return {6'h00, m < lo, m > hi};
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (n >= 100) hung("axi write");
    chk("bresp", 32'h0, {30'h0, bresp});
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    chk("rresp", 32'h0, {30'h0, rresp});
    rready <= 1'b0;
    if (n >= 100) hung("axi read");
  endtask
  // One link byte through the host command registers
  task automatic i2c_op(input logic [3:0] cmd, input logic [7:0] b,
    input logic nack, output logic [7:0] rd);
    logic [31:0] r;
    int n;
    n = 0;
    axi_wr(`SLS_CSR_WDATA, {24'h0, b});
    axi_wr(`SLS_CSR_CMD, {28'h0, cmd});
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 3000) hung("link byte");
    // A refused byte raises its event before the stop ends; wait for idle
    r = 32'h1;
    for (int k = 0; k < 50 && r[0] !== 1'b0; k++) begin
      axi_rd(`SLS_CSR_STATUS, r);
    end
    if (r[0] !== 1'b0) hung("idle");
    axi_rd(`SLS_CSR_EVT, r);
    chk("byte event", {30'h0, nack, 1'b1}, r);
    axi_rd(`SLS_CSR_RDATA, r);
    rd = r[7:0];
  endtask
  task automatic dev_rd(input logic [7:0] a, input int n, input logic rep,
    output logic [31:0] q);
    logic [7:0] r;
    q = 32'h0;
    i2c_op(4'h3, `SLS_ADDR_WR, 1'b0, r);
    i2c_op(rep ? 4'h1 : 4'h9, a, 1'b0, r);
    i2c_op(4'h3, `SLS_ADDR_RD, 1'b0, r);
    for (int i = 0; i < n; i++) begin
      i2c_op(i == n - 1 ? 4'hD : 4'h5, 8'h00, 1'b0, r);
      q = {q[23:0], r};
    end
  endtask
  task automatic dev_wr(input logic [7:0] a, input int n,
    input logic [31:0] d);
    logic [7:0] r;
    i2c_op(4'h3, `SLS_ADDR_WR, 1'b0, r);
    i2c_op(4'h1, a, 1'b0, r);
    for (int i = 0; i < n; i++) begin
      i2c_op(i == n - 1 ? 4'h9 : 4'h1, d[8*(n-1-i) +: 8], 1'b0, r);
    end
  endtask
  // Device event strobes, one cycle wide
  task automatic ev(input logic [2:0] sel, input logic [15:0] m);
    @(posedge clock_i);
    meas <= m;
    meas_valid <= sel[0];
    prox_done <= sel[1];
    als_done <= sel[2];
    @(posedge clock_i);
    meas_valid <= 1'b0;
    prox_done <= 1'b0;
    als_done <= 1'b0;
  endtask
  initial begin
    logic [31:0] q;
    logic [7:0] r, e, v, amb;
    logic [15:0] lo, hi, m;
    void'($urandom(61));
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    axi_wr(`SLS_CSR_MASK, 32'h3);
    dev_rd(`SLS_REG_IRQ, 2, 1'b1, q);
    chk("reset flags", 32'h0001, q);
    chk("timing port", 32'h01, {24'h0, mod_timing});
    $display("test reset done");
    lo = 16'h1000 + 16'($urandom_range(0, 32'h3000));
    hi = lo + 16'h0100 + 16'($urandom_range(0, 255));
    dev_wr(`SLS_REG_LOW_HI, 4, {lo, hi});
    dev_rd(`SLS_REG_LOW_HI, 4, 1'b0, q);
    chk("limits", {lo, hi}, q);
    e = 8'h00;
    // Edges first, then a sample past each limit, then random
    for (int k = 0; k < 8; k++) begin
      m = k == 0 ? lo : k == 1 ? hi : k == 2 ? lo - 16'h1 : 16'($urandom);
      m = k == 3 ? hi + 16'h1 : m;
      ev(3'b001, m);
      e = e | lim_flags(m, lo, hi);
      if (k == 2 || k == 7) begin
        dev_rd(`SLS_REG_IRQ, 1, 1'b1, q);
        chk("limit flags", {24'h0, e}, q);
      end
    end
    ev(3'b110, 16'h0);
    e = e | 8'h0C;
    for (int k = 0; k < 2; k++) begin
      dev_rd(`SLS_REG_IRQ, 1, 1'b1, q);
      chk("ready flags", {24'h0, e}, q);
    end
    chk("pad low", 32'h0, {31'h0, link_if.int_n});
    axi_rd(`SLS_CSR_STATUS, q);
    chk("pending", 32'h4, q & 32'h4);
    $display("test events done");
    dev_wr(`SLS_REG_IRQ, 1, 32'h0);
    dev_rd(`SLS_REG_IRQ, 1, 1'b0, q);
    chk("zero write", {24'h0, e}, q);
    for (int b = 0; b < 4; b++) begin
      dev_wr(`SLS_REG_IRQ, 1, 32'h1 << b);
      e[b] = 1'b0;
      dev_rd(`SLS_REG_IRQ, 1, 1'b1, q);
      chk("one clears", {24'h0, e}, q);
    end
    chk("pad released", 32'h1, {31'h0, link_if.int_n});
    $display("test clear done");
    @(posedge clock_i);
    meas_req <= 1'b0;
    led_en <= 1'b1;
    repeat (2) @(posedge clock_i);
    chk("standby", 32'h1, {31'h0, standby});
    chk("sink off", 32'h0, {31'h0, led_sink});
    meas_req <= 1'b1;
    repeat (2) @(posedge clock_i);
    chk("sink on", 32'h1, {31'h0, led_sink});
    $display("test standby done");
    v = 8'($urandom);
    amb = 8'($urandom);
    ambient <= amb;
    dev_wr(`SLS_REG_MOD, 1, {24'h0, v});
    chk("timing port", {24'h0, v}, {24'h0, mod_timing});
    dev_rd(`SLS_REG_MOD, 2, 1'b0, q);
    chk("timing and ambient", {16'h0, v, amb}, q);
    dev_wr(`SLS_REG_MOD, 1, 32'h01);
    $display("test timing done");
    i2c_op(4'hB, 8'h30, 1'b1, r);
    axi_wr(`SLS_CSR_MASK, 32'h0);
    axi_wr(`SLS_CSR_CMD, 32'hB);
    q = 32'h1;
    for (int n = 0; n < 1000 && q[0] !== 1'b0; n++) begin
      axi_rd(`SLS_CSR_STATUS, q);
    end
    if (q[0] !== 1'b0) hung("busy");
    chk("masked irq", 32'h0, {31'h0, irq});
    axi_wr(`SLS_CSR_MASK, 32'h3);
    chk("unmasked irq", 32'h1, {31'h0, irq});
    axi_rd(`SLS_CSR_EVT, q);
    chk("nack event", 32'h3, q);
    chk("cleared irq", 32'h0, {31'h0, irq});
    axi_rd(8'h1C, q);
    chk("unmapped", 32'h0, q);
    $display("test host done");
    test_done();
  end
endmodule // testbench
